/* File: scpc_regs.vh */
/*
 * Register map, field positions, reset values and timing counts of the
 * card port controller.
 * Assumes a 100 MHz hclk and a word-aligned AHB-Lite master.
 */
// How it works
// RULE1: card regulator is on only while supply pin and serial enable bit both high.
// RULE2: one select bit in the companion regulator register picks 1.875 V or 3.0 V.
// RULE3: shutdown order is reset low, clock stopped low, I/O low, supply off.
// RULE4: software, not hardware, performs the card power-up sequence.
// RULE5: insertion or removal on presence detect raises a maskable interrupt.
// RULE6: pulled-up detect line falls on removal; a falling edge means removal.
// RULE7: the clock generator makes the internal bit clock and the card clock.
// RULE8: the clock generator feeds no source into the interrupt logic.
// RULE9: transmitter has FSM, shift register, FIFO; receiver has FSM, FIFO, control.
// RULE10: forced shutdown runs the same order, ignoring auto enable and detect events.
// RULE11: supply must be off before the card loses contact with the board.
// RULE12: registers are 16 bits wide toward the microcontroller.
// RULE13: software probes the card I/O after battery check; no answer means no card.
// RULE14: with auto shutdown enabled, a removal event starts the shutdown sequence.
`ifndef SCPC_REGS_VH
`define SCPC_REGS_VH

// ==========================================================
// register byte offsets
`define SCPC_OFF_CTRL 8'h00
`define SCPC_OFF_STAT 8'h04
`define SCPC_OFF_INT_STAT 8'h08
`define SCPC_OFF_INT_MASK 8'h0c
`define SCPC_OFF_CLKDIV 8'h10
`define SCPC_OFF_ETU 8'h14
`define SCPC_OFF_TXDATA 8'h18
`define SCPC_OFF_RXDATA 8'h1c

// ==========================================================
// control fields
`define SCPC_CTRL_AUTO_PD 0
`define SCPC_CTRL_FORCE_PD 1
`define SCPC_CTRL_RST 2
`define SCPC_CTRL_CLK_EN 3
`define SCPC_CTRL_SUPPLY 4
`define SCPC_CTRL_RESET 16'h0000

// status fields
`define SCPC_STAT_PRESENT 0
`define SCPC_STAT_PD_BUSY 1
`define SCPC_STAT_TX_FULL 2
`define SCPC_STAT_RX_EMPTY 3
`define SCPC_STAT_TX_BUSY 4
`define SCPC_STAT_RX_BUSY 5

// interrupt event fields
`define SCPC_EV_INSERT 0
`define SCPC_EV_REMOVE 1
`define SCPC_EV_PD_DONE 2
`define SCPC_EV_RX_OVR 3
`define SCPC_EV_RX_PAR 4
`define SCPC_EV_W 5

// ==========================================================
// reset values and timing
`define SCPC_CLKDIV_RESET 8'h04
`define SCPC_ETU_RESET 16'h0173
`define SCPC_CLK_NS 10
`define SCPC_PD_STEP_NS 1000
`define SCPC_PD_STEP_CYC ((`SCPC_PD_STEP_NS + `SCPC_CLK_NS - 1) / `SCPC_CLK_NS)

`endif

/* File: scpc_fifo.v */
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes both sides run on hclk; a push to a full FIFO is not taken.
 */
`timescale 1ns/1ns
module scpc_fifo #(
    parameter DW = 8,
    parameter AW = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire wr_valid,
    output wire wr_ready,
    input wire [DW-1:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    reg [AW:0] wptr_ff;
    reg [AW:0] rptr_ff;
    wire push;
    wire pop;

    // one extra pointer bit tells full from empty
    assign wr_ready = (wptr_ff ^ rptr_ff) != {1'b1, {AW{1'b0}}};
    assign rd_valid = wptr_ff != rptr_ff;
    assign rd_data = mem[rptr_ff[AW-1:0]];
    assign push = wr_valid & wr_ready;
    assign pop = rd_valid & rd_ready;

    always @(posedge hclk) begin
        if (push) begin
            mem[wptr_ff[AW-1:0]] <= wr_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_ff <= {(AW+1){1'b0}};
            rptr_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
        end
    end
endmodule

/* File: scpc_top.v */
/*
 * Card port controller: AHB-Lite register slave, clock generator,
 * transmitter and receiver with FIFOs, presence detect, hardware shutdown.
 * Assumes the companion regulator gates supply with its own serial enable
 * and that software performs card power-up through the control register.
 */
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "scpc_regs.vh"
module scpc_top #(
    parameter FIFO_AW = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    output reg card_rst,
    output reg card_clk,
    output reg card_io_o,
    output reg card_io_oe,
    input wire card_io_i,
    output reg card_supply_enable_pin,
    input wire card_presence_detect
);
    localparam PD_IDLE = 3'd0;
    localparam PD_RST = 3'd1;
    localparam PD_CLK = 3'd2;
    localparam PD_IO = 3'd3;
    localparam PD_VCC = 3'd4;
    localparam RX_IDLE = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA = 2'd2;
    localparam [31:0] PD_STEP = `SCPC_PD_STEP_CYC;

    // ==========================================================
    // bus slave
    reg wr_pend_ff;
    reg [7:0] addr_ff;
    reg [15:0] ctrl_ff;
    reg [`SCPC_EV_W-1:0] int_stat_ff;
    reg [`SCPC_EV_W-1:0] int_mask_ff;
    reg [7:0] clkdiv_ff;
    reg [15:0] etu_ff;
    reg [15:0] nxt_rdata;
    wire addr_ok;
    wire rd_take;
    wire wr_do;
    wire [15:0] status;
    reg [`SCPC_EV_W-1:0] ev_set;

    function is_off;
        input [7:0] a;
        input [7:0] off;
        begin
            is_off = a == off;
        end
    endfunction

    assign addr_ok = hsel & htrans[1] & hready;
    assign rd_take = addr_ok & ~hwrite;
    assign wr_do = wr_pend_ff;

    // ==========================================================
    // presence detect, three-stage synchroniser
    reg pd_s1_ff;
    reg pd_s2_ff;
    reg pd_s3_ff;
    reg present_ff;
    wire pd_change;
    wire removal;

    assign pd_change = (pd_s2_ff == pd_s3_ff) & (pd_s3_ff != present_ff);
    assign removal = pd_change & ~pd_s3_ff; // RULE6

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_s1_ff <= 1'b1;
            pd_s2_ff <= 1'b1;
            pd_s3_ff <= 1'b1;
            present_ff <= 1'b1;
        end else begin
            pd_s1_ff <= card_presence_detect;
            pd_s2_ff <= pd_s1_ff;
            pd_s3_ff <= pd_s2_ff;
            if (pd_change) begin
                present_ff <= pd_s3_ff;
            end
        end
    end

    // ==========================================================
    // shutdown sequencer
    reg [2:0] pd_state_ff;
    reg [2:0] nxt_pd_state;
    reg [7:0] pd_cnt_ff;
    wire pd_start;
    wire pd_step_done;
    wire pd_done;

    // removal is caught in a few cycles, well before contacts separate
    assign pd_start = (pd_state_ff == PD_IDLE) &
        ((removal & ctrl_ff[`SCPC_CTRL_AUTO_PD]) | // RULE14 RULE11
         (wr_do & is_off(addr_ff, `SCPC_OFF_CTRL) & hwdata[`SCPC_CTRL_FORCE_PD])); // RULE10
    assign pd_step_done = {24'h000000, pd_cnt_ff} == PD_STEP - 32'd1;
    assign pd_done = (pd_state_ff == PD_VCC) & pd_step_done;

    always @* begin
        nxt_pd_state = pd_state_ff;
        case (pd_state_ff)
            PD_IDLE: begin
                if (pd_start) begin
                    nxt_pd_state = PD_RST;
                end
            end
            PD_RST: begin
                if (pd_step_done) begin
                    nxt_pd_state = PD_CLK;
                end
            end
            PD_CLK: begin
                // the card clock must have parked low before I/O is pulled down
                if (pd_step_done & ~card_clk) begin
                    nxt_pd_state = PD_IO;
                end
            end
            PD_IO: begin
                if (pd_step_done) begin
                    nxt_pd_state = PD_VCC;
                end
            end
            PD_VCC: begin
                if (pd_step_done) begin
                    nxt_pd_state = PD_IDLE;
                end
            end
            default: begin
                nxt_pd_state = PD_IDLE;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_state_ff <= PD_IDLE;
            pd_cnt_ff <= 8'h00;
        end else begin
            pd_state_ff <= nxt_pd_state; // RULE3
            if (nxt_pd_state != pd_state_ff || pd_state_ff == PD_IDLE || pd_step_done) begin
                pd_cnt_ff <= 8'h00;
            end else begin
                pd_cnt_ff <= pd_cnt_ff + 8'h01;
            end
        end
    end

    // ==========================================================
    // clock generator: card clock and bit tick, no interrupt sources
    reg [7:0] cdiv_cnt_ff;
    reg [15:0] etu_cnt_ff;
    reg etu_tick_ff;
    wire clk_run;

    assign clk_run = ctrl_ff[`SCPC_CTRL_CLK_EN] & (pd_state_ff < PD_CLK);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cdiv_cnt_ff <= 8'h00;
            etu_cnt_ff <= 16'h0000;
            etu_tick_ff <= 1'b0;
            card_clk <= 1'b0;
        end else begin
            if (cdiv_cnt_ff >= clkdiv_ff) begin
                cdiv_cnt_ff <= 8'h00;
                // a stopped clock still finishes its high phase, then parks low
                card_clk <= clk_run ? ~card_clk : 1'b0; // RULE7
            end else begin
                cdiv_cnt_ff <= cdiv_cnt_ff + 8'h01;
            end
            etu_tick_ff <= etu_cnt_ff >= etu_ff; // RULE7 RULE8
            etu_cnt_ff <= (etu_cnt_ff >= etu_ff) ? 16'h0000 : etu_cnt_ff + 16'h0001;
        end
    end

    // ==========================================================
    // transmitter: FIFO, shift register, state machine
    wire tx_push;
    wire tx_wr_ready;
    wire tx_valid;
    wire [7:0] tx_data;
    reg tx_busy_ff;
    reg [10:0] tx_shift_ff;
    reg [3:0] tx_bits_ff;
    wire tx_load;
    wire supply_on;
    reg [1:0] rx_state_ff;

    assign supply_on = ctrl_ff[`SCPC_CTRL_SUPPLY] & (pd_state_ff == PD_IDLE);
    assign tx_push = wr_do & is_off(addr_ff, `SCPC_OFF_TXDATA);
    assign tx_load = ~tx_busy_ff & tx_valid & supply_on & (rx_state_ff == RX_IDLE) & etu_tick_ff;

    scpc_fifo #(.DW(8), .AW(FIFO_AW)) u_tx_fifo ( // RULE9
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_valid(tx_push),
        .wr_ready(tx_wr_ready),
        .wr_data(hwdata[7:0]),
        .rd_valid(tx_valid),
        .rd_ready(tx_load),
        .rd_data(tx_data)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_busy_ff <= 1'b0;
            tx_shift_ff <= 11'h7ff;
            tx_bits_ff <= 4'h0;
        end else if (tx_load) begin
            tx_busy_ff <= 1'b1;
            tx_shift_ff <= {1'b1, ^tx_data, tx_data, 1'b0}; // RULE9
            tx_bits_ff <= 4'h0;
        end else if (tx_busy_ff & etu_tick_ff) begin
            tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
            tx_bits_ff <= tx_bits_ff + 4'h1;
            if (tx_bits_ff == 4'ha) begin
                tx_busy_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // receiver: line synchroniser, state machine, FIFO
    reg io_s1_ff;
    reg io_s2_ff;
    reg io_s3_ff;
    reg io_ff;
    reg [15:0] rx_cnt_ff;
    reg [3:0] rx_bits_ff;
    reg [8:0] rx_shift_ff;
    reg rx_push_ff;
    wire rx_wr_ready;
    wire rx_valid;
    wire [7:0] rx_data;
    wire rx_pop;
    wire rx_sample;

    assign rx_pop = rd_take & is_off(haddr, `SCPC_OFF_RXDATA);
    assign rx_sample = rx_cnt_ff >= etu_ff;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_s1_ff <= 1'b1;
            io_s2_ff <= 1'b1;
            io_s3_ff <= 1'b1;
            io_ff <= 1'b1;
        end else begin
            io_s1_ff <= card_io_i;
            io_s2_ff <= io_s1_ff;
            io_s3_ff <= io_s2_ff;
            if (io_s2_ff == io_s3_ff) begin
                io_ff <= io_s3_ff;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= 16'h0000;
            rx_bits_ff <= 4'h0;
            rx_shift_ff <= 9'h000;
            rx_push_ff <= 1'b0;
        end else begin
            rx_push_ff <= 1'b0;
            rx_cnt_ff <= rx_cnt_ff + 16'h0001;
            case (rx_state_ff) // RULE9
                RX_IDLE: begin
                    if (~io_ff & supply_on & ~tx_busy_ff) begin
                        rx_state_ff <= RX_START;
                        rx_cnt_ff <= {1'b0, etu_ff[15:1]};
                    end
                end
                RX_START: begin
                    // half a bit in: a glitch that has gone high is dropped
                    if (rx_sample) begin
                        rx_cnt_ff <= 16'h0000;
                        rx_bits_ff <= 4'h0;
                        rx_state_ff <= io_ff ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_cnt_ff <= 16'h0000;
                        rx_shift_ff <= {io_ff, rx_shift_ff[8:1]};
                        rx_bits_ff <= rx_bits_ff + 4'h1;
                        if (rx_bits_ff == 4'h8) begin
                            rx_push_ff <= 1'b1;
                            rx_state_ff <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // a byte that arrives with the FIFO full is lost and flagged
    scpc_fifo #(.DW(8), .AW(FIFO_AW)) u_rx_fifo ( // RULE9
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_valid(rx_push_ff),
        .wr_ready(rx_wr_ready),
        .wr_data(rx_shift_ff[7:0]),
        .rd_valid(rx_valid),
        .rd_ready(rx_pop),
        .rd_data(rx_data)
    );

    // ==========================================================
    // card pins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            card_rst <= 1'b0;
            card_io_o <= 1'b0;
            card_io_oe <= 1'b1;
            card_supply_enable_pin <= 1'b0;
        end else begin
            card_rst <= ctrl_ff[`SCPC_CTRL_RST] & ~pd_done & (nxt_pd_state == PD_IDLE); // RULE3
            card_io_o <= 1'b0;
            // unpowered card or the I/O and supply shutdown phases hold I/O low; else open drain
            card_io_oe <= ~ctrl_ff[`SCPC_CTRL_SUPPLY] | (pd_state_ff >= PD_IO) |
                (tx_busy_ff & ~tx_shift_ff[0]); // RULE3
            card_supply_enable_pin <= ctrl_ff[`SCPC_CTRL_SUPPLY] &
                (pd_state_ff < PD_VCC); // RULE1 RULE3
        end
    end

    // ==========================================================
    // registers and interrupt
    assign status = {10'h000, rx_state_ff != RX_IDLE, tx_busy_ff, ~rx_valid,
        ~tx_wr_ready, pd_state_ff != PD_IDLE, present_ff};

    always @* begin
        ev_set = {`SCPC_EV_W{1'b0}};
        ev_set[`SCPC_EV_INSERT] = pd_change & pd_s3_ff; // RULE5
        ev_set[`SCPC_EV_REMOVE] = removal; // RULE5
        ev_set[`SCPC_EV_PD_DONE] = pd_done;
        ev_set[`SCPC_EV_RX_OVR] = rx_push_ff & ~rx_wr_ready;
        ev_set[`SCPC_EV_RX_PAR] = rx_push_ff & (^rx_shift_ff);
    end

    always @* begin
        nxt_rdata = 16'h0000;
        case (haddr)
            `SCPC_OFF_CTRL: nxt_rdata = ctrl_ff;
            `SCPC_OFF_STAT: nxt_rdata = status;
            `SCPC_OFF_INT_STAT: nxt_rdata = {11'h000, int_stat_ff};
            `SCPC_OFF_INT_MASK: nxt_rdata = {11'h000, int_mask_ff};
            `SCPC_OFF_CLKDIV: nxt_rdata = {8'h00, clkdiv_ff};
            `SCPC_OFF_ETU: nxt_rdata = etu_ff;
            `SCPC_OFF_RXDATA: nxt_rdata = {8'h00, rx_data};
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_ff <= `SCPC_CTRL_RESET;
            int_stat_ff <= {`SCPC_EV_W{1'b0}};
            int_mask_ff <= {`SCPC_EV_W{1'b0}};
            clkdiv_ff <= `SCPC_CLKDIV_RESET;
            etu_ff <= `SCPC_ETU_RESET;
            irq <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_ff <= addr_ok & hwrite;
            if (addr_ok) begin
                addr_ff <= haddr;
            end
            if (rd_take) begin
                hrdata <= {16'h0000, nxt_rdata}; // RULE12
            end
            if (wr_do) begin
                case (addr_ff)
                    // power-up is software's job: it sets these bits itself
                    `SCPC_OFF_CTRL: ctrl_ff <= hwdata[15:0] & 16'h001d; // RULE4 RULE12
                    `SCPC_OFF_INT_MASK: int_mask_ff <= hwdata[`SCPC_EV_W-1:0];
                    `SCPC_OFF_CLKDIV: clkdiv_ff <= hwdata[7:0];
                    `SCPC_OFF_ETU: etu_ff <= hwdata[15:0];
                    default: begin
                    end
                endcase
            end
            if (pd_done) begin
                ctrl_ff[`SCPC_CTRL_RST] <= 1'b0;
                ctrl_ff[`SCPC_CTRL_CLK_EN] <= 1'b0;
                ctrl_ff[`SCPC_CTRL_SUPPLY] <= 1'b0;
            end
            // set beats a clear in the same cycle
            int_stat_ff <= (int_stat_ff & ~((wr_do & is_off(addr_ff, `SCPC_OFF_INT_STAT)) ?
                hwdata[`SCPC_EV_W-1:0] : {`SCPC_EV_W{1'b0}})) | ev_set;
            irq <= |(int_stat_ff & int_mask_ff); // RULE5
        end
    end
endmodule

/* File: scpc_top_properties.sv */
/* port checker of the card port controller.
   assumes a bind onto scpc_top and a single hclk domain. */
`timescale 1ns/1ns
module scpc_top_properties #(
    parameter FIFO_AW = 3
) (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [7:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic irq,
    input logic card_rst,
    input logic card_clk,
    input logic card_io_o,
    input logic card_io_oe,
    input logic card_io_i,
    input logic card_supply_enable_pin,
    input logic card_presence_detect
);
    // ==========================================================
    // bus and card pin relations
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_ZERO_WAIT: assert property (hreadyout)
        else $error("slave inserted a wait state");
    AST_OKAY: assert property (!hresp)
        else $error("slave gave an error response");
    AST_HALF_WORD: assert property (hrdata[31:16] == 16'h0000)
        else $error("upper half of read data set");
    AST_READ_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    AST_OPEN_DRAIN: assert property (!card_io_o)
        else $error("io line driven high");
    AST_PARKED: assert property (!card_supply_enable_pin |-> !card_rst && !card_clk && card_io_oe)
        else $error("card lines active without supply");
    AST_RST_FIRST: assert property ($fell(card_rst) |-> card_supply_enable_pin [*8])
        else $error("supply dropped right after reset");
    AST_IO_AFTER_CLK: assert property ($rose(card_io_oe) && !card_rst |-> !card_clk)
        else $error("io pulled low before reset and clock");
    AST_SUPPLY_LAST: assert property ($fell(card_supply_enable_pin) |-> $past(card_io_oe, 50))
        else $error("supply cut before io was held low");
    AST_RST_POWERED: assert property ($rose(card_rst) |-> card_supply_enable_pin && !card_io_oe)
        else $error("card reset released without supply");
endmodule

bind scpc_top scpc_top_properties #(.FIFO_AW(FIFO_AW)) i_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .card_rst(card_rst),
    .card_clk(card_clk), .card_io_o(card_io_o), .card_io_oe(card_io_oe),
    .card_io_i(card_io_i), .card_supply_enable_pin(card_supply_enable_pin),
    .card_presence_detect(card_presence_detect));

/* File: scpc_card_model.sv */
/* behavioural card: open-drain io with pull-up, presence switch, byte receive and send.
   assumes the device pulls io low only through card_io_oe; bit time in hclk cycles. */
`timescale 1ns/1ns
module scpc_card_model #(
    parameter BIT_CYC = 16
) (
    input logic hclk,
    input logic card_rst,
    input logic card_supply_enable_pin,
    input logic regulator_enable_serial_bit,
    input logic card_io_o,
    input logic card_io_oe,
    input logic inserted,
    output logic card_io_i,
    output logic card_presence_detect
);
    logic card_drive = 1'b1;
    logic sending = 1'b0;
    logic [8:0] shift;
    logic [7:0] rx_byte;
    logic rx_par_ok;
    int rx_cnt = 0;
    wire powered = card_supply_enable_pin && regulator_enable_serial_bit;
    // pull-up: a released line reads high, never its last driven value
    assign card_io_i = (card_io_oe ? card_io_o : 1'b1) & card_drive;
    assign card_presence_detect = inserted;

    // ==========================================================
    // card to device frame; bad_par flips parity on purpose
    task send_byte(input logic [7:0] b, input logic bad_par);
        logic [9:0] f;
        f = {^b ^ bad_par, b, 1'b0};
        sending = 1'b1;
        for (int i = 0; i < 10; i++) begin
            card_drive <= f[i];
            repeat (BIT_CYC) @(posedge hclk);
        end
        card_drive <= 1'b1;
        repeat (BIT_CYC) @(posedge hclk);
        sending = 1'b0;
    endtask

    // ==========================================================
    // device to card frame, sampled mid bit
    initial begin
        forever begin
            @(negedge card_io_i);
            if (powered && card_rst && !sending) begin
                repeat (BIT_CYC / 2) @(posedge hclk);
                for (int i = 0; i < 9; i++) begin
                    repeat (BIT_CYC) @(posedge hclk);
                    shift[i] = card_io_i;
                end
                rx_byte = shift[7:0];
                rx_par_ok = ~^shift;
                rx_cnt++;
            end
        end
    end
endmodule

/* File: sim_card_port_control_tb.sv */
/* self-checking bench of the card port controller.
   assumes zero-wait AHB-Lite slave and a card model on the far side. */
`timescale 1ns/1ns
`include "scpc_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define WAIT(c, l) begin n = 0; do begin @(posedge hclk); n++; if (n > l) begin errors++; print_verdict; end end while (!(c)); end
module sim_card_port_control_tb;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, inserted;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, q;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, card_rst, card_clk, card_io_o, card_io_oe, card_io_i;
    wire card_supply_enable_pin, card_presence_detect;
    int errors = 0;
    int checks_done = 0;
    int n;

    scpc_top #(.FIFO_AW(3)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .card_rst(card_rst), .card_clk(card_clk), .card_io_o(card_io_o),
        .card_io_oe(card_io_oe), .card_io_i(card_io_i),
        .card_supply_enable_pin(card_supply_enable_pin),
        .card_presence_detect(card_presence_detect));
    // etu register is set to 15, so one bit lasts 16 hclk
    scpc_card_model #(.BIT_CYC(16)) i_card (.hclk(hclk), .card_rst(card_rst),
        .card_supply_enable_pin(card_supply_enable_pin), .regulator_enable_serial_bit(1'b1),
        .card_io_o(card_io_o), .card_io_oe(card_io_oe), .inserted(inserted),
        .card_io_i(card_io_i), .card_presence_detect(card_presence_detect));

    initial begin
        forever #5 hclk = ~hclk;
    end

    // ==========================================================
    // report and bus tasks
    task print_verdict;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        `WAIT(hreadyout === 1'b1, 20)
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        `WAIT(hreadyout === 1'b1, 20)
        q = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task chk_rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask

    task power_up;
        wr(`SCPC_OFF_CTRL, 32'h0000_0010);
        wr(`SCPC_OFF_CTRL, 32'h0000_0018);
        wr(`SCPC_OFF_CTRL, 32'h0000_001c);
        `WAIT(card_rst === 1'b1, 10)
    endtask

    // ==========================================================
    // scenarios
    task t_reset_values;
        chk_rd(`SCPC_OFF_CTRL, 32'h0000_0000);
        chk_rd(`SCPC_OFF_STAT, 32'h0000_0009);
        chk_rd(`SCPC_OFF_INT_STAT, 32'h0000_0000);
        chk_rd(`SCPC_OFF_CLKDIV, 32'h0000_0004);
        chk_rd(`SCPC_OFF_ETU, 32'h0000_0173);
        wr(`SCPC_OFF_INT_MASK, 32'hffff_001f);
        chk_rd(`SCPC_OFF_INT_MASK, 32'h0000_001f);
        wr(8'h40, 32'h0000_ffff);
        chk_rd(8'h40, 32'h0000_0000);
        wr(`SCPC_OFF_INT_MASK, 32'h0000_0000);
    endtask

    task t_power_up;
        wr(`SCPC_OFF_ETU, 32'h0000_000f);
        power_up;
        `CHK(card_io_oe, 1'b0)
        `WAIT(card_clk === 1'b0, 50)
        `WAIT(card_clk === 1'b1, 50)
        `WAIT(card_clk === 1'b0, 50)
        `CHK(n, 5)
        chk_rd(`SCPC_OFF_INT_STAT, 32'h0000_0000);
    endtask

    task t_transfer;
        wr(`SCPC_OFF_TXDATA, 32'h0000_00a5);
        `WAIT(i_card.rx_cnt == 1, 600)
        `CHK(i_card.rx_byte, 8'ha5)
        `CHK(i_card.rx_par_ok, 1'b1)
        repeat (32) @(posedge hclk);
        i_card.send_byte(8'h3c, 1'b0);
        chk_rd(`SCPC_OFF_RXDATA, 32'h0000_003c);
        i_card.send_byte(8'h5a, 1'b1);
        chk_rd(`SCPC_OFF_INT_STAT, 32'h0000_0010);
        wr(`SCPC_OFF_INT_STAT, 32'h0000_0010);
        chk_rd(`SCPC_OFF_INT_STAT, 32'h0000_0000);
    endtask

    task t_forced_down;
        wr(`SCPC_OFF_INT_MASK, 32'h0000_0004);
        wr(`SCPC_OFF_CTRL, 32'h0000_001e);
        `WAIT(card_rst === 1'b0, 5)
        `WAIT(card_supply_enable_pin === 1'b0, 2000)
        `CHK(n > 2 * `SCPC_PD_STEP_CYC, 1'b1)
        `WAIT(irq === 1'b1, 200)
        chk_rd(`SCPC_OFF_CTRL, 32'h0000_0000);
        wr(`SCPC_OFF_INT_STAT, 32'h0000_0004);
        `WAIT(irq === 1'b0, 5)
    endtask

    task t_removal;
        wr(`SCPC_OFF_INT_MASK, 32'h0000_0000);
        power_up;
        wr(`SCPC_OFF_CTRL, 32'h0000_001d);
        inserted <= 1'b0;
        `WAIT(card_rst === 1'b0, 20)
        `WAIT(card_supply_enable_pin === 1'b0, 2000)
        `CHK(irq, 1'b0)
        chk_rd(`SCPC_OFF_STAT, 32'h0000_0002);
        wr(`SCPC_OFF_INT_MASK, 32'h0000_0002);
        `WAIT(irq === 1'b1, 5)
        wr(`SCPC_OFF_INT_STAT, 32'h0000_0006);
        `WAIT(irq === 1'b0, 5)
        wr(`SCPC_OFF_INT_MASK, 32'h0000_0001);
        inserted <= 1'b1;
        `WAIT(irq === 1'b1, 20)
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        inserted = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset_values;
        t_power_up;
        t_transfer;
        t_forced_down;
        t_removal;
        print_verdict;
    end
endmodule
